// *** fault_supervisor_defines.svh ***
// shared constants for the output fault supervisor
`ifndef FAULT_SUPERVISOR_DEFINES_SVH
`define FAULT_SUPERVISOR_DEFINES_SVH

// =====================================================
// output counts and status layout
`define HS_NUM 4
`define LS_NUM 8
`define OUT_NUM 12
`define STAT_HS_LSB 0
`define STAT_LS_LSB 4

// =====================================================
// reset (default state) values of the configuration
`define OL_CFG_RST 12'h000
`define LIM_SEL_RST 4'h0
`define OC_MODE_RST 8'h00

// =====================================================
// timer widths and default durations in clock cycles
`define PEAK_W 16
`define FILT_W 16
`define PEAK_CYCLES_DEF 16'h1000
`define FILT_CYCLES_DEF 16'h0040

`endif

// *** fault_supervisor_pkg.sv ***
// state types for the output fault supervisor
`include "fault_supervisor_defines.svh"

package fault_supervisor_pkg;

	// =====================================================
	// whole-state record of the supervisor top
	typedef struct packed {
		logic [`OUT_NUM-1:0] open_load_enable_reg;
		logic [`HS_NUM-1:0] current_limit_select_reg;
		logic [`LS_NUM-1:0] overcurrent_mode_reg;
		logic brownout;
		logic [`HS_NUM-1:0] hs_drive;
		logic [`HS_NUM-1:0] hs_peak;
		logic [`HS_NUM-1:0] hs_status;
		logic fs_n;
		logic [`HS_NUM-1:0][`PEAK_W-1:0] peak_cnt;
	} sup_state_t;

	// =====================================================
	// whole-state record of one low-side channel
	typedef struct packed {
		logic [`FILT_W-1:0] filt_cnt;
		logic latched_off;
		logic drive;
		logic status;
		logic fs_latch;
		logic prev_cmd;
	} ls_state_t;

endpackage

// *** ls_chan_if.sv ***
// carrier between the supervisor and one low-side channel
`timescale 1ns/100ps
`default_nettype none

interface ls_chan_if;
	logic ce;
	logic cmd;
	logic shutdown_en;
	logic ol_en;
	logic kill;
	logic reinit;
	logic drain_high;
	logic open_load;
	logic overtemp;
	logic cs_rise;
	logic drive;
	logic status;
	logic fs_latch;

	// =====================================================
	// supervisor side and channel side
	modport supervisor (output ce, cmd, shutdown_en, ol_en, kill, reinit, drain_high, open_load, overtemp,
		cs_rise, input drive, status, fs_latch);
	modport channel (input ce, cmd, shutdown_en, ol_en, kill, reinit, drain_high, open_load, overtemp,
		cs_rise, output drive, status, fs_latch);
endinterface // ls_chan_if

`default_nettype wire

// *** ls_channel.sv ***
// one low-side output: overcurrent filter, latch-off, retry and fault latch
`timescale 1ns/100ps
`default_nettype none
`include "fault_supervisor_defines.svh"

module ls_channel #(
	parameter int unsigned FILTER_CYCLES = `FILT_CYCLES_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	ls_chan_if.channel ch
);
	fault_supervisor_pkg::ls_state_t st_reg;
	fault_supervisor_pkg::ls_state_t st_next;
	logic trip;
	logic oc_now;
	logic ol_now;

	// =====================================================
	// next-state logic
	always_comb begin
		st_next = st_reg;
		trip = 1'b0;
		ol_now = !ch.cmd && ch.ol_en && ch.open_load;
		// without shutdown a cleared overcurrent leaves no fault
		oc_now = ch.cmd && ch.shutdown_en && ch.drain_high;
		// an off command re-arms the output
		if (!ch.cmd) begin
			st_next.latched_off = 1'b0;
		end
		if (ch.cmd && !st_reg.latched_off && !ch.kill && oc_now) begin
			if (st_reg.filt_cnt >= `FILT_W'(FILTER_CYCLES - 1)) begin
				trip = 1'b1;
				st_next.filt_cnt = '0;
			end else begin
				st_next.filt_cnt = st_reg.filt_cnt + `FILT_W'(1);
			end
		end else begin
			st_next.filt_cnt = '0;
		end
		// limited output stops only on overtemperature
		if (ch.cmd && !st_reg.latched_off && !ch.kill && ch.overtemp) begin
			trip = 1'b1;
		end
		// a retry into a standing fault trips again
		if (trip) begin
			st_next.latched_off = 1'b1;
		end
		st_next.drive = ch.cmd && !st_next.latched_off && !ch.kill;
		// sticky status, set wins over clear
		st_next.status = trip || ol_now ||
			(st_reg.status && !(ch.cs_rise && !st_next.latched_off && !oc_now));
		// fault pin latch released by toggling the output
		st_next.fs_latch = trip || ol_now || (st_reg.fs_latch && (ch.cmd == st_reg.prev_cmd));
		st_next.prev_cmd = ch.cmd;
		if (ch.reinit) begin
			st_next = '0;
		end
	end

	// =====================================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
		end else if (ch.ce) begin
			st_reg <= st_next;
		end
	end

	assign ch.drive = st_reg.drive;
	assign ch.status = st_reg.status;
	assign ch.fs_latch = st_reg.fs_latch;

	// =====================================================
	// checks
	a_oc_latch_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(ch.ce && trip && !ch.reinit) |=> (st_reg.latched_off && !st_reg.drive && st_reg.status))
		else $error("overcurrent trip did not latch the output off");
	a_retry_needs_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(ch.ce && st_reg.latched_off && !ch.reinit && ch.cmd) |=> st_reg.latched_off)
		else $error("latched output restarted without an off command");
	a_limit_no_fault: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(ch.ce && !ch.shutdown_en && !ch.overtemp && !ch.open_load && !st_reg.status) |=> !st_reg.status)
		else $error("fault recorded on current-limited output");
	a_fs_held: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(ch.ce && st_reg.fs_latch && !ch.reinit && ch.cmd == st_reg.prev_cmd) |=> st_reg.fs_latch)
		else $error("fault pin latch dropped without an output toggle");
endmodule // ls_channel

`default_nettype wire

// *** mcu_model.sv ***
// microcontroller model driving commands and configuration of the supervisor
`timescale 1ns/100ps
`default_nettype none
`include "fault_supervisor_defines.svh"

module mcu_model (
	input wire logic sys_clk_in,
	output logic cfg_write_out,
	output logic [`OUT_NUM-1:0] open_load_cfg_out,
	output logic [`HS_NUM-1:0] limit_select_cfg_out,
	output logic [`LS_NUM-1:0] overcurrent_mode_cfg_out,
	output logic cs_rise_out,
	output logic [`HS_NUM-1:0] hs_cmd_out,
	output logic [`LS_NUM-1:0] ls_spi_cmd_out,
	output logic [`LS_NUM-1:0] ls_use_direct_out,
	output logic ls_direct_out
);
	// =====================================================
	// idle values; every change lands just after an edge
	initial begin
		{cfg_write_out, cs_rise_out, ls_direct_out} = 3'h0;
		{open_load_cfg_out, limit_select_cfg_out, overcurrent_mode_cfg_out} = 24'h000000;
		{hs_cmd_out, ls_spi_cmd_out, ls_use_direct_out} = 20'h00000;
	end

	// one-cycle write; data held afterwards so nothing races the pulse
	task automatic write_cfg(input logic [11:0] ol, input logic [3:0] lim, input logic [7:0] oc);
		@(posedge sys_clk_in);
		#1;
		{open_load_cfg_out, limit_select_cfg_out, overcurrent_mode_cfg_out} = {ol, lim, oc};
		cfg_write_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		cfg_write_out = 1'b0;
	endtask

	// chip-select rise seen as a one-cycle pulse
	task automatic cs_pulse();
		@(posedge sys_clk_in);
		#1;
		cs_rise_out = 1'b1;
		@(posedge sys_clk_in);
		#1;
		cs_rise_out = 1'b0;
	endtask

	task automatic set_hs(input logic [3:0] v);
		@(posedge sys_clk_in);
		#1;
		hs_cmd_out = v;
	endtask

	task automatic set_ls(input logic [7:0] v);
		@(posedge sys_clk_in);
		#1;
		ls_spi_cmd_out = v;
	endtask

	task automatic set_direct(input logic [7:0] u, input logic v);
		@(posedge sys_clk_in);
		#1;
		ls_use_direct_out = u;
		ls_direct_out = v;
	endtask

	task automatic retry_ls(input int ch);
		@(posedge sys_clk_in);
		#1;
		ls_spi_cmd_out[ch] = 1'b0;
		@(posedge sys_clk_in);
		#1;
		ls_spi_cmd_out[ch] = 1'b1;
	endtask
endmodule // mcu_model

`default_nettype wire

// *** output_fault_supervisor.sv ***
// fault supervisor for four high-side and eight low-side switch outputs
`timescale 1ns/100ps
`default_nettype none
`include "fault_supervisor_defines.svh"

module output_fault_supervisor #(
	parameter int unsigned PEAK_CYCLES = `PEAK_CYCLES_DEF,
	parameter int unsigned FILTER_CYCLES = `FILT_CYCLES_DEF
) (
	input wire logic sys_clk_in,
	input wire logic rstn_in,
	input wire logic clk_en_in,
	input wire logic cfg_write_in,
	input wire logic [`OUT_NUM-1:0] open_load_cfg_in,
	input wire logic [`HS_NUM-1:0] limit_select_cfg_in,
	input wire logic [`LS_NUM-1:0] overcurrent_mode_cfg_in,
	input wire logic cs_rise_in,
	input wire logic [`HS_NUM-1:0] hs_cmd_in,
	input wire logic [`LS_NUM-1:0] ls_spi_cmd_in,
	input wire logic [`LS_NUM-1:0] ls_use_direct_in,
	input wire logic low_side_direct_input_in,
	input wire logic [`HS_NUM-1:0] hs_gate_off_in,
	input wire logic [`HS_NUM-1:0] hs_open_load_in,
	input wire logic [`LS_NUM-1:0] ls_open_load_in,
	input wire logic [`LS_NUM-1:0] ls_drain_high_in,
	input wire logic [`OUT_NUM-1:0] overtemp_in,
	input wire logic supply_below_6v_in,
	input wire logic supply_below_5v_in,
	input wire logic ground_lost_in,
	output logic [`HS_NUM-1:0] high_side_outputs_out,
	output logic [`LS_NUM-1:0] low_side_outputs_out,
	output logic [`HS_NUM-1:0] hs_peak_limit_out,
	output logic [`OUT_NUM-1:0] status_out,
	output logic fault_indicator_pin_n_out
);
	fault_supervisor_pkg::sup_state_t st_reg;
	fault_supervisor_pkg::sup_state_t st_next;
	logic kill;
	logic reinit;
	logic [`LS_NUM-1:0] ls_cmd;
	logic [`LS_NUM-1:0] ls_drive;
	logic [`LS_NUM-1:0] ls_status;
	logic [`LS_NUM-1:0] ls_fs;

	// =====================================================
	// supply and ground supervision
	// shallow dip forces outputs off without touching state
	// lost ground forces every output off
	assign kill = supply_below_6v_in || ground_lost_in;
	// reinitialise once supply is back above the upper level
	assign reinit = st_reg.brownout && !supply_below_6v_in;

	// low-side command source, spi or the shared direct input
	assign ls_cmd = (ls_use_direct_in & {`LS_NUM{low_side_direct_input_in}}) | (~ls_use_direct_in & ls_spi_cmd_in);

	// =====================================================
	// low-side channels
	genvar gi;
	generate
		for (gi = 0; gi < `LS_NUM; gi++) begin : g_ls
			ls_chan_if lsi ();
			assign lsi.ce = clk_en_in;
			assign lsi.cmd = ls_cmd[gi];
			assign lsi.shutdown_en = st_reg.overcurrent_mode_reg[gi];
			// low-side detection enabled by a 1
			assign lsi.ol_en = st_reg.open_load_enable_reg[`STAT_LS_LSB + gi];
			assign lsi.kill = kill;
			assign lsi.reinit = reinit;
			assign lsi.drain_high = ls_drain_high_in[gi];
			assign lsi.open_load = ls_open_load_in[gi];
			assign lsi.overtemp = overtemp_in[`STAT_LS_LSB + gi];
			assign lsi.cs_rise = cs_rise_in;
			assign ls_drive[gi] = lsi.drive;
			assign ls_status[gi] = lsi.status;
			assign ls_fs[gi] = lsi.fs_latch;
			ls_channel #(
				.FILTER_CYCLES(FILTER_CYCLES)
			) u_ls (
				.sys_clk_in(sys_clk_in),
				.rstn_in(rstn_in),
				.ch(lsi.channel)
			);
		end
	endgenerate

	// =====================================================
	// high-side and configuration next state
	always_comb begin
		logic hs_on;
		logic hs_ol;
		logic hs_set;
		logic hs_clr;
		logic rt_fault;
		st_next = st_reg;
		hs_on = 1'b0;
		hs_ol = 1'b0;
		hs_set = 1'b0;
		hs_clr = 1'b0;
		rt_fault = 1'b0;
		// configuration load; a write after a dip is kept, a reinit wins below
		if (cfg_write_in) begin
			st_next.open_load_enable_reg = open_load_cfg_in;
			st_next.current_limit_select_reg = limit_select_cfg_in;
			st_next.overcurrent_mode_reg = overcurrent_mode_cfg_in;
		end
		// deep dip remembered until supply recovers
		if (supply_below_5v_in) begin
			st_next.brownout = 1'b1;
		end
		for (int i = 0; i < `HS_NUM; i++) begin
			// overtemp input carries the recovery hysteresis, so drive returns when cool
			hs_on = hs_cmd_in[i] && !overtemp_in[`STAT_HS_LSB + i] && !kill;
			st_next.hs_drive[i] = hs_on;
			if (hs_on && !st_reg.hs_drive[i] && !st_reg.current_limit_select_reg[i]) begin
				st_next.peak_cnt[i] = `PEAK_W'(PEAK_CYCLES);
			end else if (!hs_on) begin
				st_next.peak_cnt[i] = '0;
			end else if (st_reg.peak_cnt[i] != '0) begin
				st_next.peak_cnt[i] = st_reg.peak_cnt[i] - `PEAK_W'(1);
			end
			// sustain only when the select bit is 1
			st_next.hs_peak[i] = hs_on && (st_next.peak_cnt[i] != '0) && !st_reg.current_limit_select_reg[i];
			// high-side detection enabled by a 0
			hs_ol = !hs_cmd_in[i] && !st_reg.open_load_enable_reg[`STAT_HS_LSB + i] && hs_open_load_in[i];
			// open load latches only after the gate has turned the output off
			hs_set = (hs_ol && hs_gate_off_in[i]) || (hs_cmd_in[i] && overtemp_in[`STAT_HS_LSB + i]);
			// clear on chip-select rise once gone or commanded on
			hs_clr = cs_rise_in && (!hs_open_load_in[i] || hs_cmd_in[i]) && !overtemp_in[`STAT_HS_LSB + i];
			// sticky status, set wins over clear
			st_next.hs_status[i] = hs_set || (st_reg.hs_status[i] && !hs_clr);
			// high-side fault pin follows the live condition
			rt_fault = rt_fault || hs_ol || (hs_cmd_in[i] && overtemp_in[`STAT_HS_LSB + i]);
		end
		// low-side latches hold the pin low
		st_next.fs_n = !(rt_fault || (|ls_fs));
		// default state, all configuration bits zero
		if (reinit) begin
			st_next.open_load_enable_reg = `OL_CFG_RST;
			st_next.current_limit_select_reg = `LIM_SEL_RST;
			st_next.overcurrent_mode_reg = `OC_MODE_RST;
			st_next.brownout = 1'b0;
			st_next.hs_drive = '0;
			st_next.hs_peak = '0;
			st_next.hs_status = '0;
			st_next.peak_cnt = '0;
			st_next.fs_n = 1'b1;
		end
	end

	// =====================================================
	// state register, frozen while the clock enable is low
	always_ff @(posedge sys_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			st_reg <= '0;
			st_reg.fs_n <= 1'b1;
		end else if (clk_en_in) begin
			st_reg <= st_next;
		end
	end

	// =====================================================
	// outputs, all from flip-flops
	assign high_side_outputs_out = st_reg.hs_drive;
	assign low_side_outputs_out = ls_drive;
	assign hs_peak_limit_out = st_reg.hs_peak;
	assign status_out = {ls_status, st_reg.hs_status};
	assign fault_indicator_pin_n_out = st_reg.fs_n;

	// =====================================================
	// checks
	a_dip_outputs_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && supply_below_6v_in) |=> (high_side_outputs_out == '0 && low_side_outputs_out == '0))
		else $error("outputs on during undervoltage");
	a_ground_lost_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && ground_lost_in) |=> (high_side_outputs_out == '0 && low_side_outputs_out == '0))
		else $error("outputs on with ground lost");
	a_dip_keeps_cfg: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && supply_below_6v_in && !st_reg.brownout && !supply_below_5v_in && !cfg_write_in)
		|=> $stable(st_reg.overcurrent_mode_reg))
		else $error("configuration lost in shallow dip");
	a_reinit_default: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && reinit) |=> (st_reg.open_load_enable_reg == `OL_CFG_RST && status_out == '0))
		else $error("default state not entered after deep dip");
	a_hs_ol_cause: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$rose(st_reg.hs_status[0]) |-> $past(hs_cmd_in[0] && overtemp_in[0]
			|| !hs_cmd_in[0] && hs_gate_off_in[0] && hs_open_load_in[0] && !st_reg.open_load_enable_reg[0]))
		else $error("high-side status set without a cause");
	a_hs_ol_clear: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$fell(st_reg.hs_status[0]) |-> $past(cs_rise_in || reinit))
		else $error("high-side status cleared without chip-select rise");
	a_peak_at_on: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && $rose(high_side_outputs_out[0]) && !$past(st_reg.current_limit_select_reg[0]) && !reinit)
		|-> hs_peak_limit_out[0])
		else $error("peak window missing at switch-on");
	a_sustain_only: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		$past(clk_en_in && st_reg.current_limit_select_reg[0]) |-> !hs_peak_limit_out[0])
		else $error("peak limit applied with sustain selected");
	a_hs_restart: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		(clk_en_in && hs_cmd_in[0] && !overtemp_in[0] && !kill && !reinit) |=> high_side_outputs_out[0])
		else $error("high-side output not restarted after cooling");
	a_ce_freeze: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
		!clk_en_in |=> ($stable(status_out) && $stable(high_side_outputs_out) && $stable(low_side_outputs_out)))
		else $error("state moved while the clock enable was low");

	// =====================================================
	// per-output checks, high side
	generate
		for (gi = 0; gi < `HS_NUM; gi++) begin : g_hs_chk
			a_hs_on_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && hs_cmd_in[gi] && !overtemp_in[`STAT_HS_LSB + gi] && !st_reg.hs_status[gi])
				|=> !st_reg.hs_status[gi])
				else $error("high-side open load reported while on");
			a_hs_ol_on: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && !hs_cmd_in[gi] && hs_gate_off_in[gi] && hs_open_load_in[gi]
				&& !st_reg.open_load_enable_reg[`STAT_HS_LSB + gi]) |=> st_reg.hs_status[gi])
				else $error("enabled high-side open load not reported");
			a_hs_ol_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !hs_cmd_in[gi] && st_reg.open_load_enable_reg[`STAT_HS_LSB + gi]
				&& !st_reg.hs_status[gi]) |=> !st_reg.hs_status[gi])
				else $error("disabled high-side open load reported");
			// an off-state set needs the gate off
			a_hs_ol_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				($rose(st_reg.hs_status[gi]) && !$past(hs_cmd_in[gi])) |-> $past(hs_gate_off_in[gi]))
				else $error("high-side open load latched before gate off");
			// clear only once the cause is gone
			a_hs_clr_gone: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				$fell(st_reg.hs_status[gi]) |-> $past(reinit || !hs_open_load_in[gi] || hs_cmd_in[gi]))
				else $error("high-side status cleared with open load present");
			a_hs_sticky: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && !cs_rise_in && st_reg.hs_status[gi]) |=> st_reg.hs_status[gi])
				else $error("high-side status dropped without chip-select rise");
			// commanding off ends the restart cycle
			a_hs_cmd_off: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !hs_cmd_in[gi]) |=> !high_side_outputs_out[gi])
				else $error("high-side output on while commanded off");
		end
	endgenerate

	// =====================================================
	// per-output checks, low side
	generate
		for (gi = 0; gi < `LS_NUM; gi++) begin : g_ls_chk
			// no status while on with a quiet drain
			a_ls_on_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && ls_cmd[gi] && !ls_drain_high_in[gi] && !overtemp_in[`STAT_LS_LSB + gi]
				&& !status_out[`STAT_LS_LSB + gi]) |=> !status_out[`STAT_LS_LSB + gi])
				else $error("low-side status set while on and healthy");
			a_ls_no_report: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && !st_reg.overcurrent_mode_reg[gi] && !overtemp_in[`STAT_LS_LSB + gi]
				&& !ls_open_load_in[gi] && !status_out[`STAT_LS_LSB + gi]) |=> !status_out[`STAT_LS_LSB + gi])
				else $error("overcurrent reported in limit mode");
			// limit mode keeps the output on
			a_ls_limit_on: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && !kill && ls_cmd[gi] && low_side_outputs_out[gi]
				&& !st_reg.overcurrent_mode_reg[gi] && !overtemp_in[`STAT_LS_LSB + gi]) |=> low_side_outputs_out[gi])
				else $error("limited low-side output switched off");
			// a channel latch pulls the pin low
			a_ls_pin_low: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
				(clk_en_in && !reinit && ls_fs[gi]) |=> !fault_indicator_pin_n_out)
				else $error("fault pin high with a low-side latch set");
		end
	endgenerate
endmodule // output_fault_supervisor

`default_nettype wire

// *** output_fault_supervisor_tb.sv ***
// self-checking bench for the output fault supervisor
`timescale 1ns/100ps
`default_nettype none
`include "fault_supervisor_defines.svh"

module output_fault_supervisor_tb;
	// short durations keep the run brief
	localparam int unsigned PEAK = 4;
	localparam int unsigned FILT = 3;
	logic clk, rstn, ce, cfg_wr, cs_rise, ls_dir, uv6, uv5, gnd_lost, pin_n;
	logic [11:0] ol_cfg, ot, status;
	logic [3:0] lim_cfg, hs_cmd, gate_off, hs_open, hs_out, peak;
	logic [7:0] oc_cfg, ls_cmd, ls_use, ls_open, drain, ls_out;
	int fail_count = 0;
	int check_count = 0;
	wire logic [11:0] outs = {ls_out, hs_out};

	// =====================================================
	// design and controller model
	output_fault_supervisor #(.PEAK_CYCLES(PEAK), .FILTER_CYCLES(FILT)) output_fault_supervisor_inst (
		.sys_clk_in(clk), .rstn_in(rstn), .clk_en_in(ce), .cfg_write_in(cfg_wr),
		.open_load_cfg_in(ol_cfg), .limit_select_cfg_in(lim_cfg), .overcurrent_mode_cfg_in(oc_cfg),
		.cs_rise_in(cs_rise), .hs_cmd_in(hs_cmd), .ls_spi_cmd_in(ls_cmd), .ls_use_direct_in(ls_use),
		.low_side_direct_input_in(ls_dir), .hs_gate_off_in(gate_off), .hs_open_load_in(hs_open),
		.ls_open_load_in(ls_open), .ls_drain_high_in(drain), .overtemp_in(ot), .supply_below_6v_in(uv6),
		.supply_below_5v_in(uv5), .ground_lost_in(gnd_lost), .high_side_outputs_out(hs_out),
		.low_side_outputs_out(ls_out), .hs_peak_limit_out(peak), .status_out(status),
		.fault_indicator_pin_n_out(pin_n));

	mcu_model mcu_model_inst (
		.sys_clk_in(clk), .cfg_write_out(cfg_wr), .open_load_cfg_out(ol_cfg),
		.limit_select_cfg_out(lim_cfg), .overcurrent_mode_cfg_out(oc_cfg), .cs_rise_out(cs_rise),
		.hs_cmd_out(hs_cmd), .ls_spi_cmd_out(ls_cmd), .ls_use_direct_out(ls_use), .ls_direct_out(ls_dir));

	// 200 MHz clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// =====================================================
	// helpers
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic check(input logic [11:0] seen, input logic [11:0] exp, input string msg);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	// bounded wait on one output bit; running out ends the run
	task automatic wait_out(input int idx, input logic val, input string msg);
		int k;
		k = 0;
		while (outs[idx] !== val && k < 12) begin
			step(1);
			k++;
		end
		check(12'(outs[idx]), 12'(val), msg);
		if (outs[idx] !== val) conclude();
	endtask

	task automatic done(input string name);
		$display("test %s finished at %0t", name, $time);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// =====================================================
	// main sequence
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		{gate_off, hs_open, ls_open, drain, ot, uv6, uv5, gnd_lost} = 39'h0;
		step(16);
		rstn = 1'b1;
		check(status, 12'h000, "status after reset");
		check(12'(pin_n), 12'h001, "pin after reset");
		hs_open = 4'h1;
		step(3);
		check(status, 12'h000, "open load before gate off");
		{gate_off, ls_open} = {4'hF, 8'h01};
		step(2);
		check(status, 12'h001, "default open load enables");
		mcu_model_inst.cs_pulse();
		check(status, 12'h001, "open load still present");
		hs_open = 4'h0;
		mcu_model_inst.cs_pulse();
		check(status, 12'h000, "open load gone");
		{hs_open, gate_off} = {4'h1, 4'h0};
		mcu_model_inst.set_hs(4'h1);
		mcu_model_inst.cs_pulse();
		check(status, 12'h000, "open load with output on");
		mcu_model_inst.set_hs(4'h0);
		{hs_open, gate_off} = {4'h0, 4'hF};
		mcu_model_inst.write_cfg(12'h031, 4'h0, 8'h00);
		mcu_model_inst.set_ls(8'h02);
		{hs_open, ls_open} = {4'h1, 8'h03};
		step(2);
		check(status, 12'h010, "configured open load enables");
		check(12'(status[5]), 12'h000, "open load while on");
		{hs_open, ls_open} = 12'h000;
		mcu_model_inst.set_ls(8'h00);
		mcu_model_inst.cs_pulse();
		done("open_load");
		mcu_model_inst.write_cfg(12'h000, 4'h2, 8'h01);
		mcu_model_inst.set_hs(4'h3);
		step(1);
		check({8'h00, peak}, 12'h001, "peak where selected");
		check(12'(peak[1]), 12'h000, "sustain only");
		step(1);
		check(12'(peak[0]), 12'h001, "peak held");
		step(3);
		check(12'(peak[0]), 12'h000, "sustain after peak");
		mcu_model_inst.set_hs(4'h0);
		done("peak");
		mcu_model_inst.set_ls(8'h01);
		drain = 8'h01;
		step(1);
		check(12'(ls_out[0]), 12'h001, "filter holds output on");
		wait_out(4, 1'b0, "overcurrent trip");
		check(12'(status[4]), 12'h001, "overcurrent status");
		step(1);
		check(12'(pin_n), 12'h000, "fault pin latched");
		step(4);
		check(12'(ls_out[0]), 12'h000, "no restart without off");
		mcu_model_inst.cs_pulse();
		check(12'(status[4]), 12'h001, "status kept while off");
		drain = 8'h00;
		mcu_model_inst.retry_ls(0);
		wait_out(4, 1'b1, "retry restarts");
		step(1);
		check(12'(pin_n), 12'h001, "toggle clears pin");
		drain = 8'h01;
		wait_out(4, 1'b0, "second trip");
		check(12'(status[4]), 12'h001, "status still set");
		done("overcurrent");
		drain = 8'h02;
		mcu_model_inst.set_ls(8'h02);
		step(10);
		check(12'(ls_out[1]), 12'h001, "limit mode stays on");
		check(12'(status[5]), 12'h000, "no report when limiting");
		check(12'(pin_n), 12'h001, "no pin when limiting");
		drain = 8'h00;
		step(2);
		check({10'h000, ls_out[1], status[5]}, 12'h002, "clean after limiting");
		ot = 12'h020;
		wait_out(5, 1'b0, "overtemp stops limiting");
		ot = 12'h000;
		mcu_model_inst.set_ls(8'h00);
		mcu_model_inst.set_hs(4'h4);
		wait_out(2, 1'b1, "hs on");
		ot = 12'h004;
		wait_out(2, 1'b0, "thermal off");
		ot = 12'h000;
		wait_out(2, 1'b1, "restart after cooling");
		mcu_model_inst.set_hs(4'h0);
		wait_out(2, 1'b0, "commanded off");
		done("limit_thermal");
		mcu_model_inst.set_direct(8'h04, 1'b1);
		mcu_model_inst.set_ls(8'h01);
		mcu_model_inst.set_hs(4'h1);
		step(2);
		check(outs, 12'h051, "outputs before dip");
		uv6 = 1'b1;
		step(2);
		check(outs, 12'h000, "dip switches off");
		uv6 = 1'b0;
		step(2);
		check(outs, 12'h051, "state restored");
		{uv6, uv5} = 2'h3;
		step(2);
		uv5 = 1'b0;
		step(2);
		uv6 = 1'b0;
		step(1);
		check(status, 12'h000, "reinit clears status");
		mcu_model_inst.set_hs(4'h0);
		mcu_model_inst.set_hs(4'h2);
		step(1);
		check(12'(peak[1]), 12'h001, "default limit select");
		step(2);
		gnd_lost = 1'b1;
		step(2);
		check(outs, 12'h000, "ground loss");
		done("supply_ground");
		// frozen state ignores the restored ground until enabled again
		ce = 1'b0;
		gnd_lost = 1'b0;
		step(3);
		check(outs, 12'h000, "frozen while disabled");
		ce = 1'b1;
		step(2);
		check(outs, 12'h052, "resumes after enable");
		done("clock_enable");
		conclude();
	end
endmodule // output_fault_supervisor_tb

`default_nettype wire
